// ### rtl/card_info_pkg.sv
package card_info_pkg;

   // Register selects on the request port
   localparam logic [1:0] SEL_CSD  = 2'h0;
   localparam logic [1:0] SEL_RCA  = 2'h1;
   localparam logic [1:0] SEL_CFG  = 2'h2;

   // Card-specific data field positions (low bit of each field)
   localparam int CSD_CRC_LO   = 1;
   localparam int CSD_TMP_BIT  = 12;
   localparam int CSD_PERM_BIT = 13;
   localparam int CSD_COPY_BIT = 14;
   localparam int CSD_FFG_BIT  = 15;
   localparam int CSD_FF_LO    = 10;

   // Shipped card-specific data fields
   localparam logic [1:0]  CSD_LAYOUT     = 2'h0;
   localparam logic [7:0]  ACCESS_TIME    = 8'h2d;  // 2.0 x 100 us
   localparam logic [2:0]  ACCESS_UNIT    = 3'h5;   // 100 us
   localparam logic [3:0]  ACCESS_MANT    = 4'h5;   // 2.0
   localparam logic [7:0]  ACCESS_CYCLES  = 8'h00;  // units of 100 clocks
   localparam logic [2:0]  RATE_UNIT      = 3'h2;   // 10 Mbit/s
   localparam logic [3:0]  RATE_MANT      = 4'h6;   // 2.5
   localparam logic [11:0] CLASS_MASK     = 12'h1b5;
   localparam logic [3:0]  BLOCK_LEN_CODE = 4'h9;   // 512 bytes
   localparam logic        PART_READ      = 1'h1;
   localparam logic        WR_CROSS       = 1'h0;
   localparam logic        RD_CROSS       = 1'h0;
   localparam logic        DRV_STAGE      = 1'h0;
   localparam logic [11:0] SIZE_FIELD     = 12'hf59;
   localparam logic [2:0]  CUR_LOW_CODE   = 3'h7;   // 100 mA
   localparam logic [2:0]  CUR_HIGH_CODE  = 3'h6;   // 80 mA
   localparam logic [2:0]  SIZE_MULT_CODE = 3'h7;
   localparam logic        BLK_ERASE_OK   = 1'h1;
   localparam logic [6:0]  SECTOR_BLOCKS  = 7'h7f;  // 128 blocks
   localparam logic [6:0]  GROUP_SECTORS  = 7'h00;  // one sector
   localparam logic        GROUP_PRESENT  = 1'h0;
   localparam logic [2:0]  WRITE_MULTIPLE = 3'h5;   // x32
   localparam logic        PART_WRITE     = 1'h0;
   localparam logic [6:0]  CRC_DEFAULT    = 7'h00;  // arbitrary until programmed
   localparam logic [15:0] RCA_RESET      = 16'h0000;

   // Configuration register fields
   localparam logic [3:0]  CFG_LAYOUT   = 4'h0;
   localparam logic [3:0]  CFG_SPEC     = 4'h0;
   localparam logic        CFG_ERASED   = 1'h1;
   localparam logic [2:0]  CFG_SECURITY = 3'h2;
   localparam logic [3:0]  CFG_WIDTHS   = 4'h5;
   localparam logic [31:0] MAKER_WORD   = 32'h00000000;  // arbitrary value

   // Host request carrier
   typedef struct packed {
      logic         rd;
      logic         wr;
      logic [1:0]   sel;
      logic [127:0] data;
   } req_t;

   // Protection state toward the memory core
   typedef struct packed {
      logic write_block;
      logic perm;
      logic temp;
   } prot_t;

endpackage

// ### rtl/card_info_regs.sv
`timescale 1ns/1ps
// Operation
// - Access time: unit bits 2:0, mantissa 6:3
// - Clocked access part in 100-cycle units, zero
// - Rate field unit and mantissa, 25 Mbit/s
// - Command classes 0,2,4,5,7,8 advertised
// - Read block code 9, equals write code
// - Partial read flag reads one
// - Misaligned write and read flags read zero
// - Capacity from size, multiplier, block length
// - Low-supply current codes report 100 mA
// - High-supply current codes report 80 mA
// - Single-block erase flag reads one
// - Erase sector is 128 write blocks
// - Protect group size is value plus one
// - Protect group feature reads absent
// - Write time multiple code five, x32
// - Partial write flag reads zero
// - File format group and code 0,0
// - Copy and permanent bits program once; refuse
// - Temporary protect rewritable, blocks writes, resets 0
// - Writable 16-bit address, no driver stage
// - Configuration register fixed field values
module card_info_regs (
   input  wire logic                 MCLK,
   input  wire logic                 SYS_RST,
   input  wire card_info_pkg::req_t  REQ,
   output logic [127:0]              RDATA,
   output logic                      RVALID,
   output card_info_pkg::prot_t      PROT,
   output logic [39:0]               CAPACITY_BYTES
);

   // Writable card-specific state
   logic        ffg_q, copy_q, perm_q, tmp_q;
   logic        ffg_d, copy_d, perm_d, tmp_d;
   logic [1:0]  ff_q, ff_d;
   logic [6:0]  crc_q, crc_d;
   logic [15:0] rca_q, rca_d;
   logic [127:0] rdata_q, rdata_d;
   logic        rvalid_q;

   // Decode of host requests
   wire         wr_csd   = REQ.wr && (REQ.sel == card_info_pkg::SEL_CSD);
   wire         wr_rca   = REQ.wr && (REQ.sel == card_info_pkg::SEL_RCA);
   wire [127:0] wd       = REQ.data;

   // Once-only bits: a 1 sticks, a 0 write cannot undo it
   assign copy_d = copy_q | (wr_csd & wd[card_info_pkg::CSD_COPY_BIT]);
   assign perm_d = perm_q | (wr_csd & wd[card_info_pkg::CSD_PERM_BIT]);
   // Format fields are once-programmable; frozen after first nonzero write
   wire         fmt_locked = ffg_q | (ff_q != 2'h0);
   assign ffg_d = (wr_csd && !fmt_locked) ? wd[card_info_pkg::CSD_FFG_BIT] : ffg_q;
   assign ff_d  = (wr_csd && !fmt_locked) ?
                  wd[card_info_pkg::CSD_FF_LO +: 2] : ff_q;
   assign tmp_d = wr_csd ? wd[card_info_pkg::CSD_TMP_BIT] : tmp_q;
   // Checksum is taken as given; host must recompute it
   assign crc_d = wr_csd ? wd[card_info_pkg::CSD_CRC_LO +: 7] : crc_q;
   assign rca_d = wr_rca ? wd[15:0] : rca_q;

   // Card-specific data image; only listed fields take writes
   wire [127:0] csd_img = {
      card_info_pkg::CSD_LAYOUT, 6'h00,
      1'b0, card_info_pkg::ACCESS_MANT, card_info_pkg::ACCESS_UNIT,
      card_info_pkg::ACCESS_CYCLES,
      1'b0, card_info_pkg::RATE_MANT, card_info_pkg::RATE_UNIT,
      card_info_pkg::CLASS_MASK,
      card_info_pkg::BLOCK_LEN_CODE,
      card_info_pkg::PART_READ,
      card_info_pkg::WR_CROSS, card_info_pkg::RD_CROSS,
      card_info_pkg::DRV_STAGE, 2'h0,
      card_info_pkg::SIZE_FIELD,
      card_info_pkg::CUR_LOW_CODE, card_info_pkg::CUR_HIGH_CODE,
      card_info_pkg::CUR_LOW_CODE, card_info_pkg::CUR_HIGH_CODE,
      card_info_pkg::SIZE_MULT_CODE,
      card_info_pkg::BLK_ERASE_OK,
      card_info_pkg::SECTOR_BLOCKS,
      card_info_pkg::GROUP_SECTORS,
      card_info_pkg::GROUP_PRESENT, 2'h0,
      card_info_pkg::WRITE_MULTIPLE,
      card_info_pkg::BLOCK_LEN_CODE,
      card_info_pkg::PART_WRITE, 5'h00,
      ffg_q, copy_q, perm_q, tmp_q, ff_q, 2'h0,
      crc_q, 1'b1};

   // Configuration image, maker word fixed
   wire [63:0]  cfg_img = {card_info_pkg::CFG_LAYOUT, card_info_pkg::CFG_SPEC,
                           card_info_pkg::CFG_ERASED, card_info_pkg::CFG_SECURITY,
                           card_info_pkg::CFG_WIDTHS, 16'h0000,
                           card_info_pkg::MAKER_WORD};

   // Read mux; an unknown select reads zero
   always_comb begin
      case (REQ.sel)
         card_info_pkg::SEL_CSD: rdata_d = csd_img;
         card_info_pkg::SEL_RCA: rdata_d = {112'h0, rca_q};
         card_info_pkg::SEL_CFG: rdata_d = {64'h0, cfg_img};
         default:                rdata_d = 128'h0;
      endcase
   end

   // Capacity = (size+1) << (mult+2) << block code
   wire [5:0]   cap_shift = 6'(card_info_pkg::SIZE_MULT_CODE) + 6'h2 +
                            6'(card_info_pkg::BLOCK_LEN_CODE);
   assign CAPACITY_BYTES = (40'(card_info_pkg::SIZE_FIELD) + 40'h1) << cap_shift;

   // Either protect bit refuses writes and erases
   assign PROT.perm        = perm_q;
   assign PROT.temp        = tmp_q;
   assign PROT.write_block = perm_q | tmp_q;

   assign RDATA  = rdata_q;
   assign RVALID = rvalid_q;

   // State registers
   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         {ffg_q, copy_q, perm_q, tmp_q, ff_q} <= 6'h00;
         crc_q    <= card_info_pkg::CRC_DEFAULT;
         rca_q    <= card_info_pkg::RCA_RESET;
         rdata_q  <= 128'h0;
         rvalid_q <= 1'b0;
      end else begin
         {ffg_q, copy_q, perm_q, tmp_q, ff_q} <= {ffg_d, copy_d, perm_d, tmp_d, ff_d};
         crc_q    <= crc_d;
         rca_q    <= rca_d;
         rdata_q  <= REQ.rd ? rdata_d : rdata_q;
         rvalid_q <= REQ.rd;
      end
   end

endmodule

// ### bench/card_info_regs_chk.sv
`timescale 1ns/1ps
module card_info_regs_chk (
   input wire logic                 MCLK,
   input wire logic                 SYS_RST,
   input wire card_info_pkg::req_t  REQ,
   input wire logic [127:0]         RDATA,
   input wire logic                 RVALID,
   input wire card_info_pkg::prot_t PROT,
   input wire logic [39:0]          CAPACITY_BYTES
);
   // Read strobes decoded for the CSD and configuration registers, plus the temporary-protect write strobe
   wire csd_rd = REQ.rd && REQ.sel == card_info_pkg::SEL_CSD;
   wire cfg_rd = REQ.rd && REQ.sel == card_info_pkg::SEL_CFG;
   wire tmp_wr = REQ.wr && REQ.sel == card_info_pkg::SEL_CSD && REQ.data[12];
   default clocking @(posedge MCLK); endclocking
   default disable iff (SYS_RST);
   property p_len; csd_rd |=> RVALID && RDATA[83:80] == 4'h9 && RDATA[25:22] == 4'h9; endproperty
   a_len: assert property (p_len) else $error("block length codes wrong");
   property p_part; csd_rd |=> RDATA[79:76] == 4'h8 && !RDATA[21]; endproperty
   a_part: assert property (p_part) else $error("partial or cross flags wrong");
   property p_cls; csd_rd |=> RDATA[95:84] == 12'h1b5; endproperty
   a_cls: assert property (p_cls) else $error("class mask wrong");
   property p_cur; csd_rd |=> RDATA[61:50] == 12'hfbe; endproperty
   a_cur: assert property (p_cur) else $error("current codes wrong");
   property p_cfg; cfg_rd |=> RDATA[63:48] == 16'h00a5 && RDATA[47:32] == 16'h0000; endproperty
   a_cfg: assert property (p_cfg) else $error("configuration fields wrong");
   property p_cap; CAPACITY_BYTES == 40'h003d680000; endproperty
   a_cap: assert property (p_cap) else $error("capacity wrong");
   property p_blk; PROT.write_block == (PROT.perm | PROT.temp); endproperty
   a_blk: assert property (p_blk) else $error("write block not perm or temp");
   property p_tmp; tmp_wr |=> PROT.temp && PROT.write_block; endproperty
   a_tmp: assert property (p_tmp) else $error("temporary protect not taken");
endmodule
bind card_info_regs card_info_regs_chk i_card_info_regs_chk (.MCLK(MCLK), .SYS_RST(SYS_RST),
   .REQ(REQ), .RDATA(RDATA), .RVALID(RVALID), .PROT(PROT), .CAPACITY_BYTES(CAPACITY_BYTES));

// ### bench/card_host_model.sv
`timescale 1ns/1ps
module card_host_model (
   input  wire logic            MCLK,
   input  wire logic [127:0]    RDATA,
   output card_info_pkg::req_t  REQ
);
   initial REQ = '0;
   // One-edge read; data sampled once the answer edge settles
   task automatic host_read(input logic [1:0] sel, output logic [127:0] d);
      @(posedge MCLK);
      REQ.rd <= 1'b1;
      REQ.sel <= sel;
      @(posedge MCLK);
      REQ.rd <= 1'b0;
      #1 d = RDATA;
   endtask
   // Caller supplies the checksum inside d; data inverted when idle
   task automatic host_write(input logic [1:0] sel, input logic [127:0] d);
      @(posedge MCLK);
      REQ.wr <= 1'b1;
      REQ.sel <= sel;
      REQ.data <= d;
      @(posedge MCLK);
      REQ.wr <= 1'b0;
      REQ.data <= ~d;
      // Let the write land before the caller looks at protection
      #1;
   endtask
endmodule

// ### bench/card_info_regs_tb.sv
`timescale 1ns/1ps
module card_info_regs_tb;
   localparam logic [127:0] IMG = 128'h002d0032_1b5983d6_7efbff80_16400001;
   logic                 mclk = 1'b0;
   logic                 sys_rst = 1'b1;
   card_info_pkg::req_t  req;
   card_info_pkg::prot_t prot;
   logic [127:0]         rdata;
   logic [127:0]         d;
   logic [39:0]          cap;
   int                   err_total = 0;
   int                   n_compared = 0;
   int                   cyc = 0;
   always #5 mclk = ~mclk;
   card_host_model i_card_host_model (.MCLK(mclk), .RDATA(rdata), .REQ(req));
   card_info_regs i_card_info_regs (.MCLK(mclk), .SYS_RST(sys_rst), .REQ(req),
      .RDATA(rdata), .RVALID(), .PROT(prot), .CAPACITY_BYTES(cap));
   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Hang guard, well above the roughly 35 cycles needed
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         report_and_stop();
      end
   end
   initial begin
      repeat (12) @(posedge mclk);
      sys_rst <= 1'b0;
      check({125'h0, prot}, 128'h0);
      check({88'h0, cap}, 128'h3d680000);
      i_card_host_model.host_read(card_info_pkg::SEL_CSD, d);
      check(d, IMG);
      i_card_host_model.host_read(card_info_pkg::SEL_CFG, d);
      check(d, 128'h00a5000000000000);
      $display("test shipped contents done");
      i_card_host_model.host_write(card_info_pkg::SEL_RCA, 128'hbeef);
      i_card_host_model.host_read(card_info_pkg::SEL_RCA, d);
      check(d, 128'hbeef);
      i_card_host_model.host_read(2'h3, d);
      check(d, 128'h0);
      $display("test address done");
      i_card_host_model.host_write(card_info_pkg::SEL_CSD, IMG | 128'h1000);
      check({125'h0, prot}, 128'h5);
      i_card_host_model.host_write(card_info_pkg::SEL_CSD, IMG);
      check({125'h0, prot}, 128'h0);
      $display("test temporary protect done");
      // Inverted read-only bits must be ignored
      i_card_host_model.host_write(card_info_pkg::SEL_CSD, {~IMG[127:16], 16'hfcff});
      i_card_host_model.host_read(card_info_pkg::SEL_CSD, d);
      check(d, IMG | 128'hfcfe);
      check({125'h0, prot}, 128'h7);
      i_card_host_model.host_write(card_info_pkg::SEL_CSD, IMG);
      i_card_host_model.host_read(card_info_pkg::SEL_CSD, d);
      check(d, IMG | 128'hec00);
      check({125'h0, prot}, 128'h6);
      $display("test one-time bits done");
      report_and_stop();
   end
endmodule
